// ### core/fsw_consts.svh
// How it works
// - Parameter table byte 6Ch reads E8h, low seven bits code status write method.
// - After power-up, status register 1 takes the last non-volatile value.
// - Instruction 06h arms the next status write into non-volatile storage.
// - Instruction 50h arms a volatile status write that overrides until power-off.
// - Soft reset happens only when 66h is directly followed by 99h.
// - Reset-enable and reset are recognised on one, two or four wires.
// - Parameter table byte 6Dh reads 10h, reporting the 66h/99h reset sequence.
`ifndef FSW_CONSTS_SVH
`define FSW_CONSTS_SVH

`define FSW_CMD_WREN_NV 8'h06
`define FSW_CMD_WREN_VOL 8'h50
`define FSW_CMD_WRSR 8'h01
`define FSW_CMD_RST_EN 8'h66
`define FSW_CMD_RST 8'h99
`define FSW_CMD_TABLE_RD 8'h5A

`define FSW_TBL_ADDR_WRMODE 8'h6C
`define FSW_TBL_VAL_WRMODE 8'hE8
`define FSW_TBL_ADDR_RESET 8'h6D
`define FSW_TBL_VAL_RESET 8'h10
`define FSW_TBL_ADDR_4B_EXIT 8'h6E
`define FSW_TBL_VAL_4B_EXIT 8'hC0
`define FSW_TBL_ADDR_4B_ENTER 8'h6F
`define FSW_TBL_VAL_4B_ENTER 8'h80
`define FSW_TBL_VAL_BLANK 8'hFF

`define FSW_ADDR_BYTES 2'h3
`define FSW_BITS_PER_BYTE 4'h8

`endif

// ### core/fsw_pkg.sv
package fsw_pkg;

  typedef enum logic [1:0] {FSW_W1, FSW_W2, FSW_W4} fsw_width_t;

  typedef enum logic [2:0] {FSW_CMD, FSW_ADDR, FSW_DUMMY, FSW_DATA, FSW_WRSR, FSW_IGNORE} fsw_state_t;

endpackage

// ### core/fsw_core.sv
`timescale 1ns/1ps
`include "fsw_consts.svh"

module fsw_core
  import fsw_pkg::*;
(
  // Clock and reset
  input logic clock_i,
  input logic reset_i,
  // Serial link
  input logic sclk_i,
  input logic cs_n_i,
  input logic [3:0] dq_i,
  output logic [3:0] dq_o,
  output logic [3:0] dq_oe_o,
  // Active interface width
  input fsw_width_t width_i,
  // Non-volatile status storage
  input logic [7:0] nv_status_i,
  output logic nv_write_o,
  output logic [7:0] nv_data_o,
  // Status and reset
  output logic [7:0] status_o,
  output logic soft_reset_o
);

  logic sclk_q;
  logic rise;
  logic fall;
  fsw_state_t st;
  logic [3:0] cnt;
  logic [3:0] ocnt;
  logic [3:0] lanes;
  logic [7:0] sh;
  logic [7:0] sh_in;
  logic [7:0] osh;
  logic [7:0] addr;
  logic [1:0] abytes;
  logic byte_done;
  logic obyte_done;
  logic cmd_done;
  logic wrsr_done;
  logic wel_nv;
  logic wel_vol;
  logic rst_en;
  logic [7:0] out_byte;

  function automatic logic [7:0] fsw_table(input logic [7:0] a);
    unique case (a)
      `FSW_TBL_ADDR_WRMODE: fsw_table = `FSW_TBL_VAL_WRMODE;
      `FSW_TBL_ADDR_RESET: fsw_table = `FSW_TBL_VAL_RESET;
      `FSW_TBL_ADDR_4B_EXIT: fsw_table = `FSW_TBL_VAL_4B_EXIT;
      `FSW_TBL_ADDR_4B_ENTER: fsw_table = `FSW_TBL_VAL_4B_ENTER;
      default: fsw_table = `FSW_TBL_VAL_BLANK;
    endcase
  endfunction

  always_ff @(posedge clock_i) begin
    sclk_q <= reset_i ? 1'b0 : sclk_i;
  end

  assign rise = sclk_i & ~sclk_q & ~cs_n_i;
  assign fall = ~sclk_i & sclk_q & ~cs_n_i;

  // Bits taken per clock follow the active width
  always_comb begin
    unique case (width_i)
      FSW_W1: begin
        lanes = 4'h1;
        sh_in = {sh[6:0], dq_i[0]};
      end
      FSW_W2: begin
        lanes = 4'h2;
        sh_in = {sh[5:0], dq_i[1:0]};
      end
      FSW_W4: begin
        lanes = 4'h4;
        sh_in = {sh[3:0], dq_i};
      end
      default: begin
        lanes = 4'h1;
        sh_in = {sh[6:0], dq_i[0]};
      end
    endcase
  end

  assign byte_done = rise && ((cnt + lanes) == `FSW_BITS_PER_BYTE);
  assign obyte_done = (ocnt + lanes) == `FSW_BITS_PER_BYTE;
  assign cmd_done = byte_done && (st == FSW_CMD);
  assign wrsr_done = byte_done && (st == FSW_WRSR);
  assign out_byte = (ocnt == 4'h0) ? fsw_table(addr) : osh;

  // Instruction decode and framing
  always_ff @(posedge clock_i) begin
    if (reset_i || cs_n_i) begin
      st <= FSW_CMD;
      cnt <= 4'h0;
      sh <= 8'h00;
      abytes <= 2'h0;
    end else if (rise) begin
      sh <= sh_in;
      cnt <= byte_done ? 4'h0 : 4'(cnt + lanes);
      if (byte_done) begin
        unique case (st)
          FSW_CMD: begin
            if (sh_in == `FSW_CMD_TABLE_RD) begin
              st <= FSW_ADDR;
            end else if (sh_in == `FSW_CMD_WRSR) begin
              st <= FSW_WRSR;
            end else begin
              st <= FSW_IGNORE;
            end
          end
          FSW_ADDR: begin
            abytes <= 2'(abytes + 2'h1);
            if (2'(abytes + 2'h1) == `FSW_ADDR_BYTES) begin
              st <= FSW_DUMMY;
            end
          end
          FSW_DUMMY: st <= FSW_DATA;
          FSW_WRSR: st <= FSW_IGNORE;
          FSW_DATA, FSW_IGNORE: st <= st;
        endcase
      end
    end
  end

  // Table address: last address byte is the table offset, then steps by one
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      addr <= 8'h00;
    end else if (byte_done && st == FSW_ADDR) begin
      addr <= sh_in;
    end else if (fall && st == FSW_DATA && obyte_done) begin
      addr <= 8'(addr + 8'h01);
    end
  end

  // Table data driven on the falling serial edge
  always_ff @(posedge clock_i) begin
    if (reset_i || cs_n_i || st != FSW_DATA) begin
      dq_o <= 4'h0;
      dq_oe_o <= 4'h0;
      ocnt <= 4'h0;
      osh <= 8'h00;
    end else if (fall) begin
      ocnt <= obyte_done ? 4'h0 : 4'(ocnt + lanes);
      osh <= 8'(out_byte << lanes);
      unique case (width_i)
        FSW_W2: begin
          dq_o <= {2'b00, out_byte[7:6]};
          dq_oe_o <= 4'h3;
        end
        FSW_W4: begin
          dq_o <= out_byte[7:4];
          dq_oe_o <= 4'hF;
        end
        default: begin
          dq_o <= {2'b00, out_byte[7], 1'b0};
          dq_oe_o <= 4'h2;
        end
      endcase
    end
  end

  // Write-enable latches survive chip select; consumed by the status write
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wel_nv <= 1'b0;
      wel_vol <= 1'b0;
    end else if (wrsr_done || (cmd_done && rst_en && sh_in == `FSW_CMD_RST)) begin
      wel_nv <= 1'b0;
      wel_vol <= 1'b0;
    end else if (cmd_done && sh_in == `FSW_CMD_WREN_NV) begin
      wel_nv <= 1'b1;
    end else if (cmd_done && sh_in == `FSW_CMD_WREN_VOL) begin
      wel_vol <= 1'b1;
    end
  end

  // Status register: loaded from storage at power-up, volatile writes override
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      status_o <= nv_status_i;
    end else if (wrsr_done && (wel_nv || wel_vol)) begin
      status_o <= sh_in;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      nv_write_o <= 1'b0;
      nv_data_o <= 8'h00;
    end else begin
      nv_write_o <= wrsr_done && wel_nv;
      if (wrsr_done && wel_nv) begin
        nv_data_o <= sh_in;
      end
    end
  end

  // Reset-enable holds only until the next instruction
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rst_en <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      soft_reset_o <= cmd_done && rst_en && (sh_in == `FSW_CMD_RST);
      if (cmd_done) begin
        rst_en <= (sh_in == `FSW_CMD_RST_EN);
      end
    end
  end

  sequence s_armed_reset;
    cmd_done && rst_en && (sh_in == `FSW_CMD_RST);
  endsequence

  sequence s_table_start(logic [7:0] a);
    fall && st == FSW_DATA && ocnt == 4'h0 && addr == a;
  endsequence

  property p_table_6c;
    @(posedge clock_i) disable iff (reset_i)
    s_table_start(`FSW_TBL_ADDR_WRMODE) |=>
      (width_i == FSW_W4) ? (dq_o == 4'hE) : (dq_o[1] == 1'b1);
  endproperty
  a_table_6c: assert property (p_table_6c) else $error("table byte 6C wrong");

  property p_powerup;
    @(posedge clock_i) reset_i |=> status_o == $past(nv_status_i);
  endproperty
  a_powerup: assert property (p_powerup) else $error("status not loaded from storage");

  property p_nv_write;
    @(posedge clock_i) disable iff (reset_i)
    nv_write_o |-> $past(wel_nv) && status_o == nv_data_o;
  endproperty
  a_nv_write: assert property (p_nv_write) else $error("storage written without enable");

  property p_vol_write;
    @(posedge clock_i) disable iff (reset_i)
    ($past(!reset_i) && status_o != $past(status_o) && !nv_write_o) |-> $past(wel_vol);
  endproperty
  a_vol_write: assert property (p_vol_write) else $error("status changed without enable");

  property p_sw_reset;
    @(posedge clock_i) disable iff (reset_i)
    s_armed_reset |=> soft_reset_o ##1 !soft_reset_o;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("soft reset not issued");

  property p_reset_cause;
    @(posedge clock_i) disable iff (reset_i)
    soft_reset_o |-> $past(rst_en) && !rst_en;
  endproperty
  a_reset_cause: assert property (p_reset_cause) else $error("soft reset without enable");

  property p_width;
    @(posedge clock_i) disable iff (reset_i)
    (rise && width_i == FSW_W4) |-> (byte_done == (cnt == 4'h4));
  endproperty
  a_width: assert property (p_width) else $error("quad byte framed wrong");

  property p_table_6d;
    @(posedge clock_i) disable iff (reset_i)
    s_table_start(`FSW_TBL_ADDR_RESET) |=>
      (width_i == FSW_W4) ? (dq_o == 4'h1) : (dq_o[1] == 1'b0);
  endproperty
  a_table_6d: assert property (p_table_6d) else $error("table byte 6D wrong");

  property p_addr_step;
    @(posedge clock_i) disable iff (reset_i)
    (fall && st == FSW_DATA && obyte_done && !cs_n_i) |=> addr == 8'($past(addr) + 8'h01);
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("table address did not advance");

endmodule

// ### test/fsw_host.sv
`timescale 1ns/1ps
module fsw_host
  import fsw_pkg::*;
(
  // Clock and mode
  input logic clock_i,
  input fsw_width_t width_i,
  // Serial link
  input logic [3:0] miso_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] sio_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sio_o = 4'h0;
  end
  // Idle lanes toggle so a stale value never looks valid
  task automatic sel(input logic n);
    @(posedge clock_i);
    cs_n_o <= n;
    sio_o <= ~sio_o;
  endtask
  // One byte out and in, MSB first, three clocks per sclk phase
  task automatic xb(input logic [7:0] b, output logic [7:0] r);
    int n;
    logic [3:0] v;
    n = (width_i == FSW_W4) ? 4 : (width_i == FSW_W2) ? 2 : 1;
    r = 8'h00;
    for (int i = 0; i < 8; i += n) begin
      @(posedge clock_i);
      v = ~sio_o;
      case (n)
        1: v[0] = b[7];
        2: v[1:0] = b[7:6];
        default: v = b[7:4];
      endcase
      sio_o <= v;
      b = b << n;
      repeat (2) @(posedge clock_i);
      r = (n == 1) ? {r[6:0], miso_i[1]} : (n == 2) ? {r[5:0], miso_i[1:0]} : {r[3:0], miso_i};
      sclk_o <= 1'b1;
      repeat (3) @(posedge clock_i);
      sclk_o <= 1'b0;
    end
  endtask
endmodule

// ### test/tb_flash_status_write_and_soft_reset.sv
`timescale 1ns/1ps
module tb_flash_status_write_and_soft_reset
  import fsw_pkg::*;
;
  logic clock_i, reset_i, sclk, cs_n, nv_write_o, soft_reset_o;
  logic [3:0] sio, dq_o, dq_oe_o, miso;
  logic [7:0] nv_status_i, nv_data_o, status_o, r;
  fsw_width_t width_i;
  int num_errors, checks, nvc, src, n0;
  logic [7:0] tbl [5] = '{8'hFF, 8'hE8, 8'h10, 8'hC0, 8'h80};

  fsw_core dut (.clock_i, .reset_i, .sclk_i(sclk), .cs_n_i(cs_n), .dq_i(sio), .dq_o, .dq_oe_o,
    .width_i, .nv_status_i, .nv_write_o, .nv_data_o, .status_o, .soft_reset_o);
  fsw_host host (.clock_i, .width_i, .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .sio_o(sio));
  // Undriven lanes read back inverted so a stale bit cannot pass
  assign miso = (dq_o & dq_oe_o) | ~(dq_o | dq_oe_o);

  always #2 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    if (nv_write_o === 1'b1) nvc++;
    if (soft_reset_o === 1'b1) src++;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic do_reset(input logic [7:0] nv);
    @(posedge clock_i);
    nv_status_i <= nv;
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] b, input logic two);
    host.sel(1'b0);
    host.xb(a, r);
    if (two) host.xb(b, r);
    host.sel(1'b1);
    repeat (4) @(posedge clock_i);
  endtask

  task automatic t_nv;
    do_reset(8'hA5);
    chk("status after reset", 8'hA5, status_o);
    n0 = nvc;
    frame(8'h01, 8'h77, 1'b1);
    chk("unarmed write", 8'hA5, status_o);
    frame(8'h06, 8'h00, 1'b0);
    frame(8'h01, 8'h5A, 1'b1);
    chk("nv status", 8'h5A, status_o);
    chk("nv data", 8'h5A, nv_data_o);
    frame(8'h01, 8'h11, 1'b1);
    chk("second write", 8'h5A, status_o);
    chk("nv pulses", 8'h01, 8'(nvc - n0));
  endtask
  task automatic t_vol;
    n0 = nvc;
    frame(8'h50, 8'h00, 1'b0);
    frame(8'h01, 8'hC3, 1'b1);
    chk("volatile status", 8'hC3, status_o);
    chk("volatile pulses", 8'h00, 8'(nvc - n0));
    do_reset(8'h3C);
    chk("power up", 8'h3C, status_o);
  endtask
  task automatic t_reset(input fsw_width_t w);
    width_i <= w;
    n0 = src;
    frame(8'h66, 8'h00, 1'b0);
    frame(8'h99, 8'h00, 1'b0);
    frame(8'h99, 8'h00, 1'b0);
    frame(8'h66, 8'h00, 1'b0);
    frame(8'h06, 8'h00, 1'b0);
    frame(8'h99, 8'h00, 1'b0);
    chk("soft resets", 8'h01, 8'(src - n0));
  endtask
  task automatic t_table(input fsw_width_t w, input logic [3:0] oe);
    width_i <= w;
    host.sel(1'b0);
    host.xb(8'h5A, r);
    host.xb(8'h00, r);
    host.xb(8'h00, r);
    host.xb(8'h6B, r);
    host.xb(8'h00, r);
    for (int k = 0; k < 5; k++) begin
      host.xb(8'h00, r);
      chk("table byte", tbl[k], r);
    end
    chk("output enable", {4'h0, oe}, {4'h0, dq_oe_o});
    host.sel(1'b1);
    repeat (4) @(posedge clock_i);
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    wrap_up;
  end
  initial begin
    clock_i = 1'b0;
    reset_i = 1'b1;
    width_i = FSW_W1;
    nv_status_i = 8'h00;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    t_nv;
    t_vol;
    t_reset(FSW_W1);
    t_reset(FSW_W2);
    t_reset(FSW_W4);
    t_reset(fsw_width_t'(2'h3));
    t_table(FSW_W1, 4'h2);
    t_table(FSW_W2, 4'h3);
    t_table(FSW_W4, 4'hF);
    wrap_up;
  end
endmodule
